// *** logic/board_reset_sequencer.sv ***
module board_reset_sequencer (
    input  wire logic                                       clk_in,
    input  wire logic                                       reset_in,
    input  wire logic                                       power_button_in,
    input  wire logic                                       hw_reset_button_in,
    input  wire logic [reset_seq_pkg::BOARD_COUNT-1:0]      board_reset_request_in,
    input  wire logic                                       assert_por_option_in,
    input  wire logic                                       config_done_in,
    output logic [reset_seq_pkg::BOARD_COUNT-1:0]           system_reset_n_out,
    output logic [reset_seq_pkg::BOARD_COUNT-1:0]           power_on_reset_n_out,
    output logic                                            periph_system_reset_n_out,
    output logic                                            periph_power_on_reset_n_out,
    output logic                                            board_power_en_out,
    output logic                                            config_start_out,
    output logic                                            defaults_load_out,
    output logic                                            run_out
);

    // ****************************************************************
    // Input conditioning.
    // ****************************************************************
    localparam int unsigned NIN = reset_seq_pkg::BOARD_COUNT + 2;

    logic [NIN-1:0] raw_inputs;
    logic [NIN-1:0] presses;
    logic           soft_press;
    logic           hw_press;
    logic           req_press;

    assign raw_inputs = {board_reset_request_in, hw_reset_button_in, power_button_in};

    // One debouncer per input line.
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_deb
            input_debounce u_deb (
                .clk_in    (clk_in),
                .reset_in  (reset_in),
                .level_in  (raw_inputs[gi]),
                .press_out (presses[gi])
            );
        end
    endgenerate

    assign soft_press = presses[0];
    assign hw_press   = presses[1];
    assign req_press  = |presses[NIN-1:2];

    // ****************************************************************
    // Sequencer.
    // ****************************************************************
    reset_seq_pkg::seq_state_t            state_ff;
    reset_seq_pkg::seq_state_t            nxt_state;
    logic [reset_seq_pkg::CNT_W-1:0]      timer_ff;
    logic [reset_seq_pkg::CNT_W-1:0]      nxt_timer;
    logic                                 por_on_ff;
    logic                                 nxt_por_on;
    logic                                 sys_n_ff;
    logic                                 nxt_sys_n;
    logic                                 por_n_ff;
    logic                                 nxt_por_n;
    logic                                 power_ff;
    logic                                 nxt_power;
    logic                                 cfg_start_ff;
    logic                                 nxt_cfg_start;
    logic                                 defaults_ff;
    logic                                 nxt_defaults;
    logic                                 run_ff;
    logic                                 nxt_run;
    logic                                 timer_done;

    assign timer_done = (timer_ff == reset_seq_pkg::CNT_ZERO);

    // Next-state logic; the hardware button has priority in every powered state.
    always_comb begin
        nxt_state     = state_ff;
        nxt_timer     = timer_done ? timer_ff : timer_ff - 16'h0001;
        nxt_por_on    = por_on_ff;
        nxt_sys_n     = sys_n_ff;
        nxt_por_n     = por_n_ff;
        nxt_power     = power_ff;
        nxt_cfg_start = 1'b0;
        nxt_defaults  = 1'b0;
        case (state_ff)
            reset_seq_pkg::ST_STANDBY: begin
                nxt_sys_n = 1'b0;
                nxt_por_n = 1'b0;
                nxt_power = 1'b0;
                if (soft_press) begin
                    nxt_state     = reset_seq_pkg::ST_CONFIG;
                    nxt_power     = 1'b1;
                    nxt_cfg_start = 1'b1;
                end
            end
            reset_seq_pkg::ST_CONFIG: begin
                if (config_done_in) begin
                    nxt_state = reset_seq_pkg::ST_REL_POR;
                    nxt_timer = reset_seq_pkg::CNT_W'(reset_seq_pkg::STAGE_CYCLES);
                    nxt_por_on = 1'b1;
                end
            end
            reset_seq_pkg::ST_ASSERT: begin
                if (timer_done) begin
                    nxt_state = reset_seq_pkg::ST_REL_POR;
                    nxt_timer = reset_seq_pkg::CNT_W'(reset_seq_pkg::STAGE_CYCLES);
                end
            end
            reset_seq_pkg::ST_REL_POR: begin
                nxt_por_n = 1'b1;
                if (timer_done) begin
                    nxt_state = reset_seq_pkg::ST_REL_SYS;
                end
            end
            reset_seq_pkg::ST_REL_SYS: begin
                nxt_sys_n = 1'b1;
                nxt_state = reset_seq_pkg::ST_RUN;
            end
            reset_seq_pkg::ST_RUN: begin
                if (soft_press || req_press) begin
                    nxt_state  = reset_seq_pkg::ST_ASSERT;
                    nxt_timer  = reset_seq_pkg::CNT_W'(reset_seq_pkg::STAGE_CYCLES);
                    nxt_sys_n  = 1'b0;
                    nxt_por_on = assert_por_option_in;
                    nxt_por_n  = !assert_por_option_in;
                end
            end
            default: begin
                nxt_state = reset_seq_pkg::ST_STANDBY;
            end
        endcase
        if (hw_press && state_ff != reset_seq_pkg::ST_STANDBY) begin
            nxt_state    = reset_seq_pkg::ST_STANDBY;
            nxt_sys_n    = 1'b0;
            nxt_por_n    = 1'b0;
            nxt_power    = 1'b0;
            nxt_por_on   = 1'b0;
            nxt_defaults = 1'b1;
        end
        nxt_run = (nxt_state == reset_seq_pkg::ST_RUN);
    end

    // State registers; reset leaves the board in standby with resets held.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff     <= reset_seq_pkg::ST_STANDBY;
            timer_ff     <= reset_seq_pkg::CNT_ZERO;
            por_on_ff    <= 1'b0;
            sys_n_ff     <= 1'b0;
            por_n_ff     <= 1'b0;
            power_ff     <= 1'b0;
            cfg_start_ff <= 1'b0;
            defaults_ff  <= 1'b0;
            run_ff       <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            timer_ff     <= nxt_timer;
            por_on_ff    <= nxt_por_on;
            sys_n_ff     <= nxt_sys_n;
            por_n_ff     <= nxt_por_n;
            power_ff     <= nxt_power;
            cfg_start_ff <= nxt_cfg_start;
            defaults_ff  <= nxt_defaults;
            run_ff       <= nxt_run;
        end
    end

    // The reset pair travels as one carrier, so both levels always leave together.
    reset_seq_pkg::board_resets_t reset_pair;

    assign reset_pair = '{system_reset_n: sys_n_ff, power_on_reset_n: por_n_ff};

    // Fan the same reset pair out to every board and to the peripherals.
    assign system_reset_n_out          = {reset_seq_pkg::BOARD_COUNT{reset_pair.system_reset_n}};
    assign power_on_reset_n_out        = {reset_seq_pkg::BOARD_COUNT{reset_pair.power_on_reset_n}};
    assign periph_system_reset_n_out   = reset_pair.system_reset_n;
    assign periph_power_on_reset_n_out = reset_pair.power_on_reset_n;
    assign board_power_en_out          = power_ff;
    assign config_start_out            = cfg_start_ff;
    assign defaults_load_out           = defaults_ff;
    assign run_out                     = run_ff;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_soft_start;
        state_ff == reset_seq_pkg::ST_RUN && (soft_press || req_press) && !hw_press;
    endsequence

    chk_seq_assert: assert property (@(posedge clk_in) disable iff (reset_in)
        s_soft_start |=> !sys_n_ff && (por_n_ff == !$past(assert_por_option_in)))
        else $error("Reset sequence start drove the wrong reset levels.");

    chk_por_before_sys: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(sys_n_ff) |-> $past(por_n_ff))
        else $error("System reset released before power-on reset.");

    chk_run_after_release: assert property (@(posedge clk_in) disable iff (reset_in)
        run_ff |-> sys_n_ff && por_n_ff)
        else $error("Run state reached with a reset still held.");

    chk_hw_standby: assert property (@(posedge clk_in) disable iff (reset_in)
        (hw_press && state_ff != reset_seq_pkg::ST_STANDBY) |=> !power_ff && !sys_n_ff && defaults_ff)
        else $error("Hardware button did not reach standby.");

    chk_standby_exit: assert property (@(posedge clk_in) disable iff (reset_in)
        (state_ff == reset_seq_pkg::ST_STANDBY && !soft_press) |=> state_ff == reset_seq_pkg::ST_STANDBY)
        else $error("Standby left without the power button.");

    chk_no_reconfig: assert property (@(posedge clk_in) disable iff (reset_in)
        state_ff != reset_seq_pkg::ST_STANDBY |=> !config_start_out)
        else $error("Reconfiguration started outside power up.");

    chk_config_first: assert property (@(posedge clk_in) disable iff (reset_in)
        state_ff == reset_seq_pkg::ST_CONFIG |-> !sys_n_ff && !por_n_ff)
        else $error("Resets released during configuration.");

    // The hard-reset flag must agree with the power-on reset level in the assert state.
    chk_por_flag_match: assert property (@(posedge clk_in) disable iff (reset_in)
        state_ff == reset_seq_pkg::ST_ASSERT |-> (por_on_ff == !por_n_ff))
        else $error("Hard reset flag disagrees with power-on reset level.");

    chk_req_sequence: assert property (@(posedge clk_in) disable iff (reset_in)
        s_soft_start |=> state_ff == reset_seq_pkg::ST_ASSERT ##[1:600] state_ff == reset_seq_pkg::ST_REL_POR)
        else $error("Request did not run the reset sequence.");

endmodule : board_reset_sequencer

// *** logic/reset_seq_pkg.sv ***
package reset_seq_pkg;

    // ****************************************************************
    // Board count and timing.
    // ****************************************************************
    localparam int unsigned BOARD_COUNT = 2;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Debounce time for buttons and request lines, in microseconds.
    localparam int unsigned DEBOUNCE_US = 10;
    localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
    // Time each reset stage is held, in microseconds.
    localparam int unsigned STAGE_US = 20;
    localparam int unsigned STAGE_CYCLES = (STAGE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // ****************************************************************
    // Sequencer states.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_STANDBY  = 3'b000,
        ST_CONFIG   = 3'b001,
        ST_ASSERT   = 3'b010,
        ST_REL_POR  = 3'b011,
        ST_REL_SYS  = 3'b100,
        ST_RUN      = 3'b101
    } seq_state_t;

    // Reset outputs that travel together to each board.
    typedef struct packed {
        logic system_reset_n;
        logic power_on_reset_n;
    } board_resets_t;

endpackage : reset_seq_pkg

// *** logic/input_debounce.sv ***
// Synchronises one level input and emits a one-cycle pulse when a stable
// assertion has been held for the debounce time.
module input_debounce (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic level_in,
    output logic      press_out
);

    logic                                 meta_ff;
    logic                                 sync_ff;
    logic                                 stable_ff;
    logic                                 nxt_stable;
    logic [reset_seq_pkg::CNT_W-1:0]      cnt_ff;
    logic [reset_seq_pkg::CNT_W-1:0]      nxt_cnt;
    logic                                 press_ff;
    logic                                 nxt_press;

    // Filter counts how long the synchronised level differs from the stable one.
    always_comb begin
        nxt_cnt    = reset_seq_pkg::CNT_ZERO;
        nxt_stable = stable_ff;
        nxt_press  = 1'b0;
        if (sync_ff != stable_ff) begin
            if (cnt_ff == reset_seq_pkg::CNT_W'(reset_seq_pkg::DEBOUNCE_CYCLES - 1)) begin
                nxt_stable = sync_ff;
                nxt_press  = sync_ff;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    // Registers for the synchroniser, filter and pulse.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta_ff   <= 1'b0;
            sync_ff   <= 1'b0;
            stable_ff <= 1'b0;
            cnt_ff    <= reset_seq_pkg::CNT_ZERO;
            press_ff  <= 1'b0;
        end else begin
            meta_ff   <= level_in;
            sync_ff   <= meta_ff;
            stable_ff <= nxt_stable;
            cnt_ff    <= nxt_cnt;
            press_ff  <= nxt_press;
        end
    end

    assign press_out = press_ff;

    chk_single_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
        press_out |=> !press_out)
        else $error("Debounce pulse lasted more than one cycle.");

endmodule : input_debounce

// *** tb/board_partner.sv ***
// Far-side model: two board controllers that turn a debug system reset into a
// reset request, and an external configuration procedure that reports done.
module board_partner (
    input  wire logic [reset_seq_pkg::BOARD_COUNT-1:0] debug_system_reset_n_in,
    input  wire logic                                  clk_in,
    input  wire logic                                  config_start_in,
    input  wire logic [7:0]                            cfg_delay_in,
    output logic [reset_seq_pkg::BOARD_COUNT-1:0]      board_reset_request_out,
    output logic                                       config_done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wait_ff;

    // Each board raises its request while its debug reset is held low.
    assign board_reset_request_out = ~debug_system_reset_n_in;

    // Done drops at every start and rises after the configured delay.
    initial begin
        config_done_out = 1'h0;
        wait_ff = 8'h00;
    end
    always @(negedge clk_in) begin
        if (config_start_in) begin
            config_done_out <= 1'h0;
            wait_ff         <= cfg_delay_in;
        end else if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
            if (wait_ff == 8'h01) begin
                config_done_out <= 1'h1;
            end
        end
    end
endmodule : board_partner

// *** tb/board_reset_sequencer_tb.sv ***
module board_reset_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NB = reset_seq_pkg::BOARD_COUNT;
    logic          clk_in = 1'h0;
    logic          reset_in = 1'h1;
    logic          power_button_in = 1'h0;
    logic          hw_reset_button_in = 1'h0;
    logic          assert_por_option_in = 1'h0;
    logic [NB-1:0] debug_n = '1;
    logic [7:0]    cfg_delay = 8'h0a;
    logic [NB-1:0] request, sys_n, por_n;
    logic          config_done, psys_n, ppor_n, power_en, cfg_start, dfl_load, run;
    logic          cfg_seen, dfl_seen, por_low, sys_low, pwr_drop, por_prev, sys_prev;
    int            err_count = 0;
    int            total_checks = 0;
    int            seed = 31;
    int            cyc = 0;
    int            t_por = 0;
    int            t_sys = 0;
    int            which_tab [4] = '{0, 0, 2, 3};

    always #20 clk_in = ~clk_in;

    board_reset_sequencer board_reset_sequencer_inst (
        .clk_in(clk_in), .reset_in(reset_in), .power_button_in(power_button_in),
        .hw_reset_button_in(hw_reset_button_in), .board_reset_request_in(request),
        .assert_por_option_in(assert_por_option_in), .config_done_in(config_done),
        .system_reset_n_out(sys_n), .power_on_reset_n_out(por_n), .periph_system_reset_n_out(psys_n),
        .periph_power_on_reset_n_out(ppor_n), .board_power_en_out(power_en),
        .config_start_out(cfg_start), .defaults_load_out(dfl_load), .run_out(run));

    board_partner board_partner_inst (
        .debug_system_reset_n_in(debug_n), .clk_in(clk_in), .config_start_in(cfg_start),
        .cfg_delay_in(cfg_delay), .board_reset_request_out(request), .config_done_out(config_done));

    // Reports a mismatch between a seen and an expected value.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Watches the outputs after each rising edge has settled.
    always @(posedge clk_in) begin
        #1;
        cyc++;
        if (cfg_start) cfg_seen = 1'h1;
        if (dfl_load) dfl_seen = 1'h1;
        if (!(&por_n)) por_low = 1'h1;
        if (!(&sys_n)) sys_low = 1'h1;
        if (!power_en) pwr_drop = 1'h1;
        if (&por_n && !por_prev) t_por = cyc;
        if (&sys_n && !sys_prev) t_sys = cyc;
        por_prev = &por_n;
        sys_prev = &sys_n;
        if (!reset_in) check({sys_n, por_n}, {{NB{psys_n}}, {NB{ppor_n}}}, "board and periph resets");
    end

    // Holds one input active for n cycles: 0 power, 1 hardware, 2+ board debug reset.
    task automatic hold(input int which, input int n);
        @(negedge clk_in);
        if (which == 0) power_button_in = 1'h1;
        else if (which == 1) hw_reset_button_in = 1'h1;
        else debug_n[which-2] = 1'h0;
        repeat (n) @(negedge clk_in);
        power_button_in = 1'h0;
        hw_reset_button_in = 1'h0;
        debug_n = '1;
    endtask : hold

    // Clears the event flags before a case.
    task automatic clear_flags;
        @(negedge clk_in);
        {cfg_seen, dfl_seen, por_low, sys_low, pwr_drop} = 5'h00;
    endtask : clear_flags

    // Presses one source and follows the sequence until the boards run again.
    task automatic seq_case(input int which, input logic opt, input logic exp_por, input logic exp_cfg);
        int n;
        assert_por_option_in = opt;
        cfg_delay = 8'h01 + 8'($unsigned($random(seed)) % 60);
        clear_flags();
        hold(which, 260 + $unsigned($random(seed)) % 140);
        n = 0;
        while (!run && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 3000) begin
            check(0, 1, "run timeout");
            stop_test();
        end
        check(run, 1'h1, "run after sequence");
        check(sys_low, 1'h1, "system reset asserted");
        check(por_low, exp_por, "power-on reset asserted");
        check(cfg_seen, exp_cfg, "configuration start");
        // Power is seen off only when the case started from standby.
        check({dfl_seen, pwr_drop}, {1'h0, exp_cfg}, "no defaults, power held");
        if (exp_por) check(t_sys - t_por >= int'(reset_seq_pkg::STAGE_CYCLES), 1'h1, "release order");
        $display("case source %0d option %0d done", which, opt);
    endtask : seq_case

    initial begin
        int w;
        logic o;
        repeat (2) @(negedge clk_in);
        reset_in = 1'h0;
        check({sys_n, por_n, power_en, cfg_start, dfl_load, run}, '0, "reset values");
        // Neither the hardware button nor a request may leave standby.
        clear_flags();
        hold(1, 300);
        hold(2, 300);
        repeat (300) @(negedge clk_in);
        check({power_en, cfg_seen, run}, 3'h0, "standby kept");
        $display("case standby kept done");
        seq_case(0, 1'($random(seed)), 1'h1, 1'h1);
        for (int i = 0; i < 6; i++) begin
            w = (i < 4) ? which_tab[i] : (($unsigned($random(seed)) % 3 == 0) ? 0 : 2 + i % 2);
            o = (i < 2) ? i[0] : 1'($random(seed));
            seq_case(w, o, o, 1'h0);
            if (i < 2) check(por_low, i[0], "option controls power-on reset");
        end
        // A press shorter than the filter time starts nothing.
        clear_flags();
        hold(0, 20 + $unsigned($random(seed)) % 180);
        repeat (400) @(negedge clk_in);
        check({run, sys_low}, 2'h2, "short press ignored");
        $display("case short press done");
        // Hardware button drops power and loads defaults.
        clear_flags();
        hold(1, 300);
        check({power_en, run, sys_n, por_n, dfl_seen}, 7'h01, "hardware reset to standby");
        $display("case hardware reset done");
        seq_case(0, 1'h0, 1'h1, 1'h1);
        stop_test();
    end
endmodule : board_reset_sequencer_tb
